// *** hw/t16cc_params.svh ***
// Purpose: Constants of the timer compare, capture and flag block
// Assumes: Included by its bare name
// Notes: Register byte offsets on APB, field positions, reset values
`ifndef T16CC_PARAMS_SVH
`define T16CC_PARAMS_SVH
`define T16CC_OFS_MASK 8'h00
`define T16CC_OFS_FLAGS 8'h04
`define T16CC_OFS_CMPA_L 8'h08
`define T16CC_OFS_CMPA_H 8'h0C
`define T16CC_OFS_CMPB_L 8'h10
`define T16CC_OFS_CMPB_H 8'h14
`define T16CC_OFS_CAP_L 8'h18
`define T16CC_OFS_CAP_H 8'h1C
`define T16CC_OFS_CTRL 8'h20
`define T16CC_BIT_CAP 5
`define T16CC_BIT_CMPA 4
`define T16CC_BIT_CMPB 3
`define T16CC_BIT_OVF 2
`define T16CC_CTRL_EDGE 6
`define T16CC_CTRL_SRC 7
`define T16CC_CTRL_FORCE_A 8
`define T16CC_CTRL_FORCE_B 9
`define T16CC_RST_BYTE 8'h00
`define T16CC_RST_WORD 16'h0000
`define T16CC_RST_MODE 4'h0
`define T16CC_MAX 16'hFFFF
`define T16CC_BOTTOM 16'h0000
`define T16CC_TOP_8 16'h00FF
`define T16CC_TOP_9 16'h01FF
`define T16CC_TOP_10 16'h03FF
`endif

// *** hw/t16cc_pkg.sv ***
// Purpose: Types of the timer compare, capture and flag block
// Assumes: Nothing
// Notes: Flag struct order is capture, compare A, compare B, overflow
package t16cc_pkg;
  typedef struct packed {
    logic cap;
    logic cmpa;
    logic cmpb;
    logic ovf;
  } t16cc_flags_t;
  typedef struct packed {
    logic tick;
    logic [15:0] value;
  } t16cc_cnt_t;
  typedef struct packed {
    logic [3:0] mode;
    logic edge_rise;
    logic src_analog;
  } t16cc_ctrl_t;
endpackage

// *** hw/t16cc_top.sv ***
// Purpose: Compare, capture and interrupt flags of a 16-bit timer, APB slave
// Assumes: Counter, waveform generator and CPU core sit outside
// Notes: Shared high-byte latch for 16-bit compare writes and capture reads
// Overview of operation
// - Both compare values checked against the counter on every timer tick.
// - Compare writes pass through the shared high-byte latch; high byte first.
// - Reading capture low byte latches the matching high byte for later read.
// - Qualifying capture event copies the counter; comparator may be the source.
// - Capture value serves as counter top in the modes that select it.
// - Capture request needs mask bit 5, global enable and capture flag.
// - Compare A request needs mask bit 4, global enable and its flag.
// - Compare B request needs mask bit 3, global enable and its flag.
// - Overflow request needs mask bit 2, global enable and overflow flag.
// - Capture flag set per event, or at top when capture is top.
// - Capture flag cleared by vector execution or writing one.
// - Compare A flag set on the tick after counter equals compare A.
// - Compare B flag set on the tick after counter equals compare B.
// - Forced compare strobes never set a compare flag.
// - Compare flags cleared by vector execution or writing one.
// - Overflow flag set at max, bottom or top as the mode defines, in every mode but 13, which never sets it.
// - Overflow flag cleared by vector execution or writing one.
// - Capture input ignored while capture value is the top.
// - Edge select zero captures falling edges, one captures rising edges.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "t16cc_params.svh"
module t16cc_top import t16cc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire t16cc_cnt_t cnt_i,
  input wire logic capture_pin_i,
  input wire logic analog_cmp_i,
  input wire logic global_irq_enable_i,
  input wire t16cc_flags_t vector_ack_i,
  output t16cc_flags_t irq_req_o,
  output logic [15:0] top_value_o,
  output logic [3:0] waveform_mode_o,
  output logic compare_a_match_o,
  output logic compare_b_match_o
);
  logic [7:0] mask, next_mask;
  t16cc_flags_t flags, next_flags;
  logic [15:0] compare_value_a, next_compare_value_a;
  logic [15:0] compare_value_b, next_compare_value_b;
  logic [15:0] capture_value, next_capture_value;
  logic [7:0] temp, next_temp;
  t16cc_ctrl_t ctrl, next_ctrl;
  logic src_prev, next_src_prev;
  logic pend_a, next_pend_a;
  logic pend_b, next_pend_b;
  logic match_a, next_match_a;
  logic match_b, next_match_b;
  logic [31:0] rdata, next_rdata;
  logic slverr, next_slverr;
  logic [15:0] top_value, next_top_value;
  logic setup, wr, hit;
  logic [7:0] addr;
  logic icr_top, non_pwm, src, cap_evt, ovf_evt;
  logic eq_a, eq_b, at_top;
  logic force_a, force_b;
  t16cc_flags_t set_f, clr_f, w1c;

  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign addr = 8'(paddr_i);
  assign pready_o = 1'b1;
  assign prdata_o = rdata;
  assign pslverr_o = slverr;
  assign top_value_o = top_value;
  assign waveform_mode_o = ctrl.mode;
  assign compare_a_match_o = match_a;
  assign compare_b_match_o = match_b;

  // Top of the mode being written, registered below
  always_comb begin
    next_top_value = `T16CC_MAX;
    case (next_ctrl.mode)
      4'd1, 4'd5: next_top_value = `T16CC_TOP_8;
      4'd2, 4'd6: next_top_value = `T16CC_TOP_9;
      4'd3, 4'd7: next_top_value = `T16CC_TOP_10;
      4'd4, 4'd9, 4'd11, 4'd15: next_top_value = next_compare_value_a;
      4'd8, 4'd10, 4'd12, 4'd14: next_top_value = next_capture_value;
      default: next_top_value = `T16CC_MAX;
    endcase
  end

  // Current mode only, so the capture path forms no loop
  always_comb begin
    icr_top = 1'b0;
    non_pwm = 1'b0;
    case (ctrl.mode)
      4'd0, 4'd4: non_pwm = 1'b1;
      4'd12: begin
        non_pwm = 1'b1;
        icr_top = 1'b1;
      end
      4'd8, 4'd10, 4'd14: icr_top = 1'b1;
      default: non_pwm = 1'b0;
    endcase
  end

  // Counter events seen on a timer tick
  always_comb begin
    eq_a = cnt_i.value == compare_value_a;
    eq_b = cnt_i.value == compare_value_b;
    at_top = cnt_i.tick && cnt_i.value == top_value;
    ovf_evt = 1'b0;
    case (ctrl.mode)
      4'd0, 4'd4, 4'd12: ovf_evt = cnt_i.tick && cnt_i.value == `T16CC_MAX;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: ovf_evt = at_top;
      4'd13: ovf_evt = 1'b0;
      default: ovf_evt = cnt_i.tick && cnt_i.value == `T16CC_BOTTOM;
    endcase
    src = ctrl.src_analog ? analog_cmp_i : capture_pin_i;
    cap_evt = !icr_top &&
              (ctrl.edge_rise ? (src && !src_prev) : (!src && src_prev));
  end

  // Register file and flag logic
  always_comb begin
    next_mask = mask;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_capture_value = capture_value;
    next_temp = temp;
    next_ctrl = ctrl;
    next_rdata = rdata;
    next_slverr = slverr;
    next_src_prev = src;
    force_a = 1'b0;
    force_b = 1'b0;
    w1c = '0;
    hit = 1'b1;
    if (wr) begin
      if (addr == `T16CC_OFS_MASK) begin
        next_mask = pwdata_i[7:0];
      end else if (addr == `T16CC_OFS_FLAGS) begin
        w1c.cap = pwdata_i[`T16CC_BIT_CAP];
        w1c.cmpa = pwdata_i[`T16CC_BIT_CMPA];
        w1c.cmpb = pwdata_i[`T16CC_BIT_CMPB];
        w1c.ovf = pwdata_i[`T16CC_BIT_OVF];
      end else if (addr == `T16CC_OFS_CMPA_H || addr == `T16CC_OFS_CMPB_H ||
                   addr == `T16CC_OFS_CAP_H) begin
        next_temp = pwdata_i[7:0];
      end else if (addr == `T16CC_OFS_CMPA_L) begin
        next_compare_value_a = {temp, pwdata_i[7:0]};
      end else if (addr == `T16CC_OFS_CMPB_L) begin
        next_compare_value_b = {temp, pwdata_i[7:0]};
      end else if (addr == `T16CC_OFS_CAP_L) begin
        next_capture_value = {temp, pwdata_i[7:0]};
      end else if (addr == `T16CC_OFS_CTRL) begin
        next_ctrl.mode = pwdata_i[3:0];
        next_ctrl.edge_rise = pwdata_i[`T16CC_CTRL_EDGE];
        next_ctrl.src_analog = pwdata_i[`T16CC_CTRL_SRC];
        force_a = pwdata_i[`T16CC_CTRL_FORCE_A];
        force_b = pwdata_i[`T16CC_CTRL_FORCE_B];
      end
    end
    if (setup) begin
      next_rdata = '0;
      if (addr == `T16CC_OFS_MASK) begin
        next_rdata[7:0] = mask;
      end else if (addr == `T16CC_OFS_FLAGS) begin
        next_rdata[`T16CC_BIT_CAP] = flags.cap;
        next_rdata[`T16CC_BIT_CMPA] = flags.cmpa;
        next_rdata[`T16CC_BIT_CMPB] = flags.cmpb;
        next_rdata[`T16CC_BIT_OVF] = flags.ovf;
      end else if (addr == `T16CC_OFS_CMPA_L) begin
        next_rdata[7:0] = compare_value_a[7:0];
      end else if (addr == `T16CC_OFS_CMPA_H) begin
        next_rdata[7:0] = compare_value_a[15:8];
      end else if (addr == `T16CC_OFS_CMPB_L) begin
        next_rdata[7:0] = compare_value_b[7:0];
      end else if (addr == `T16CC_OFS_CMPB_H) begin
        next_rdata[7:0] = compare_value_b[15:8];
      end else if (addr == `T16CC_OFS_CAP_L) begin
        next_rdata[7:0] = capture_value[7:0];
        if (!pwrite_i) begin
          next_temp = capture_value[15:8];
        end
      end else if (addr == `T16CC_OFS_CAP_H) begin
        next_rdata[7:0] = temp;
      end else if (addr == `T16CC_OFS_CTRL) begin
        next_rdata[3:0] = ctrl.mode;
        next_rdata[`T16CC_CTRL_EDGE] = ctrl.edge_rise;
        next_rdata[`T16CC_CTRL_SRC] = ctrl.src_analog;
      end else begin
        hit = 1'b0;
      end
      next_slverr = !hit;
    end
    // Capture beats a same-cycle CPU write
    if (cap_evt) begin
      next_capture_value = cnt_i.value;
    end
    next_pend_a = cnt_i.tick ? eq_a : pend_a;
    next_pend_b = cnt_i.tick ? eq_b : pend_b;
    // Match strobes to the waveform generator; force only in non-PWM modes
    next_match_a = (cnt_i.tick && eq_a) || (force_a && non_pwm);
    next_match_b = (cnt_i.tick && eq_b) || (force_b && non_pwm);
    set_f.cap = cap_evt || (icr_top && at_top);
    set_f.cmpa = cnt_i.tick && pend_a;
    set_f.cmpb = cnt_i.tick && pend_b;
    set_f.ovf = ovf_evt;
    clr_f = w1c | vector_ack_i;
    // Set wins over clear
    next_flags = (flags & ~clr_f) | set_f;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask <= `T16CC_RST_BYTE;
      flags <= '0;
      compare_value_a <= `T16CC_RST_WORD;
      compare_value_b <= `T16CC_RST_WORD;
      capture_value <= `T16CC_RST_WORD;
      temp <= `T16CC_RST_BYTE;
      ctrl <= '0;
      src_prev <= 1'b0;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      match_a <= 1'b0;
      match_b <= 1'b0;
      rdata <= '0;
      slverr <= 1'b0;
      top_value <= `T16CC_MAX;
    end else begin
      mask <= next_mask;
      flags <= next_flags;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      capture_value <= next_capture_value;
      temp <= next_temp;
      ctrl <= next_ctrl;
      src_prev <= next_src_prev;
      pend_a <= next_pend_a;
      pend_b <= next_pend_b;
      match_a <= next_match_a;
      match_b <= next_match_b;
      rdata <= next_rdata;
      slverr <= next_slverr;
      top_value <= next_top_value;
    end
  end

  always_comb begin
    irq_req_o.cap = mask[`T16CC_BIT_CAP] && global_irq_enable_i && flags.cap;
    irq_req_o.cmpa = mask[`T16CC_BIT_CMPA] && global_irq_enable_i && flags.cmpa;
    irq_req_o.cmpb = mask[`T16CC_BIT_CMPB] && global_irq_enable_i && flags.cmpb;
    irq_req_o.ovf = mask[`T16CC_BIT_OVF] && global_irq_enable_i && flags.ovf;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_cap_req;
    irq_req_o.cap |-> mask[5] && global_irq_enable_i && flags.cap;
  endproperty
  a_cap_req: assert property (p_cap_req) else $error("capture request without cause");
  property p_cmpa_req;
    (flags.cmpa && mask[4] && global_irq_enable_i) |-> irq_req_o.cmpa;
  endproperty
  a_cmpa_req: assert property (p_cmpa_req) else $error("compare A request missing");
  property p_cmpb_req;
    irq_req_o.cmpb == (mask[3] && global_irq_enable_i && flags.cmpb);
  endproperty
  a_cmpb_req: assert property (p_cmpb_req) else $error("compare B request wrong");
  property p_ovf_req;
    !global_irq_enable_i |-> !irq_req_o.ovf && !irq_req_o.cap;
  endproperty
  a_ovf_req: assert property (p_ovf_req) else $error("request despite global disable");
  property p_cmpa_set;
    cnt_i.tick && pend_a |=> flags.cmpa;
  endproperty
  a_cmpa_set: assert property (p_cmpa_set) else $error("compare A flag not set");
  property p_cmpb_rise;
    $rose(flags.cmpb) |-> $past(cnt_i.tick) && $past(pend_b);
  endproperty
  a_cmpb_rise: assert property (p_cmpb_rise) else $error("compare B flag set early");
  property p_force_no_flag;
    $rose(flags.cmpa) |-> $past(pend_a);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("flag set by force");
  property p_vec_clear;
    vector_ack_i.cap && !set_f.cap |=> !flags.cap;
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("capture flag not cleared");
  property p_w0_keep;
    wr && addr == `T16CC_OFS_FLAGS && !pwdata_i[`T16CC_BIT_OVF] && flags.ovf &&
      !vector_ack_i.ovf |=> flags.ovf;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("overflow flag lost on zero write");
  property p_icr_hold;
    icr_top && !wr |=> $stable(capture_value);
  endproperty
  a_icr_hold: assert property (p_icr_hold) else $error("capture while capture is top");
  property p_rise_cap;
    !icr_top && ctrl.edge_rise && !ctrl.src_analog && capture_pin_i && !src_prev
      |=> capture_value == $past(cnt_i.value);
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("rising edge not captured");
  property p_fall_cap;
    !icr_top && !ctrl.edge_rise && !ctrl.src_analog && !capture_pin_i && src_prev
      |=> capture_value == $past(cnt_i.value);
  endproperty
  a_fall_cap: assert property (p_fall_cap) else $error("falling edge not captured");
  property p_cmpa_pend;
    cnt_i.tick && eq_a |=> pend_a;
  endproperty
  a_cmpa_pend: assert property (p_cmpa_pend) else $error("compare A match lost");
  property p_cmpb_set;
    cnt_i.tick && pend_b |=> flags.cmpb;
  endproperty
  a_cmpb_set: assert property (p_cmpb_set) else $error("compare B flag not set");
  property p_cmpa_vec;
    vector_ack_i.cmpa && !set_f.cmpa |=> !flags.cmpa;
  endproperty
  a_cmpa_vec: assert property (p_cmpa_vec) else $error("compare A flag not cleared");
  property p_cmpb_vec;
    vector_ack_i.cmpb && !set_f.cmpb |=> !flags.cmpb;
  endproperty
  a_cmpb_vec: assert property (p_cmpb_vec) else $error("compare B flag not cleared");
  property p_ovf_vec;
    vector_ack_i.ovf && !set_f.ovf |=> !flags.ovf;
  endproperty
  a_ovf_vec: assert property (p_ovf_vec) else $error("overflow flag not cleared");
  property p_ovf_max;
    cnt_i.tick && cnt_i.value == `T16CC_MAX && (ctrl.mode == 4'd0 || ctrl.mode == 4'd12)
      |=> flags.ovf;
  endproperty
  a_ovf_max: assert property (p_ovf_max) else $error("overflow at max not flagged");
  property p_cap_set;
    cap_evt |=> flags.cap;
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("capture flag not set");
  property p_cap_top;
    icr_top && at_top |=> flags.cap;
  endproperty
  a_cap_top: assert property (p_cap_top) else $error("capture flag not set at top");
  property p_w1c_spare;
    wr && addr == `T16CC_OFS_FLAGS && !pwdata_i[`T16CC_BIT_CMPB] && flags.cmpb &&
      !vector_ack_i.cmpb |=> flags.cmpb;
  endproperty
  a_w1c_spare: assert property (p_w1c_spare) else $error("other flag disturbed");
  property p_force_pulse;
    wr && addr == `T16CC_OFS_CTRL && pwdata_i[`T16CC_CTRL_FORCE_A] && non_pwm
      |=> compare_a_match_o;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("forced strobe missing");
  property p_cmpa_high;
    wr && addr == `T16CC_OFS_CMPA_L |=> compare_value_a[15:8] == $past(temp);
  endproperty
  a_cmpa_high: assert property (p_cmpa_high) else $error("high byte not from latch");
  property p_cap_latch;
    setup && !pwrite_i && addr == `T16CC_OFS_CAP_L |=> temp == 8'($past(capture_value) >> 8);
  endproperty
  a_cap_latch: assert property (p_cap_latch) else $error("capture high byte not latched");
  property p_ovf_gate;
    irq_req_o.ovf == (mask[2] && global_irq_enable_i && flags.ovf);
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request wrong");

  c_capture: cover property (cap_evt ##1 flags.cap);
  c_cmpa: cover property ($rose(flags.cmpa));
  c_ovf: cover property ($rose(flags.ovf) && irq_req_o.ovf);
  c_cap_read: cover property (setup && addr == `T16CC_OFS_CAP_L ##3
    setup && addr == `T16CC_OFS_CAP_H);
  c_top_cap: cover property (icr_top && at_top ##1 flags.cap);
endmodule // t16cc_top

// *** test/t16cc_cnt_model.sv ***
// Purpose: Counter model that feeds value and tick to the compare block
// Assumes: One timer tick per clock while running
// Notes: Load wins over counting; tick follows run, even in a load cycle
`timescale 1ns/1ps
module t16cc_cnt_model import t16cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  output t16cc_cnt_t cnt_o
);
  logic [15:0] value;
  logic [15:0] next_value;
  always_comb begin
    next_value = value;
    if (load_i) begin
      next_value = load_val_i;
    end else if (run_i) begin
      next_value = value + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value <= 16'h0000;
    end else begin
      value <= next_value;
    end
  end
  assign cnt_o = '{tick: run_i, value: value};
endmodule // t16cc_cnt_model

// *** test/tb_t16cc_top.sv ***
// Purpose: Self-checking bench of the compare, capture and flag block
// Assumes: APB master tasks, counter model on the far side
// Notes: Flags read over APB, requests watched at the ports
`timescale 1ns/1ps
`include "t16cc_params.svh"
module tb_t16cc_top import t16cc_pkg::*;;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = '0;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] ld_val = 16'h0000;
  logic cap_pin = 1'b1;
  logic analog = 1'b0;
  logic gie = 1'b0;
  t16cc_flags_t vack = '0;
  t16cc_flags_t irq;
  t16cc_cnt_t cnt;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] top_val;
  logic [3:0] wmode;
  logic match_a;
  logic match_b;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_ma = 0;
  int n_mb = 0;
  always #2.5 ref_clk = ~ref_clk;
  t16cc_cnt_model t16cc_cnt_model_inst (.ref_clk_i(ref_clk), .nrst_i(nrst), .run_i(run),
    .load_i(load), .load_val_i(ld_val), .cnt_o(cnt));
  t16cc_top t16cc_top_inst (.ref_clk_i(ref_clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cnt_i(cnt), .capture_pin_i(cap_pin), .analog_cmp_i(analog),
    .global_irq_enable_i(gie), .vector_ack_i(vack), .irq_req_o(irq),
    .top_value_o(top_val), .waveform_mode_o(wmode), .compare_a_match_o(match_a),
    .compare_b_match_o(match_b));
  task automatic results();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (match_a === 1'b1) begin
      n_ma++;
    end
    if (match_b === 1'b1) begin
      n_mb++;
    end
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    chk(q, exp);
  endtask
  // Load the counter, then tick n times and stop
  task automatic tick(input logic [15:0] v, input int n);
    load <= 1'b1;
    ld_val <= v;
    @(posedge ref_clk);
    load <= 1'b0;
    run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    run <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic pin(input logic l);
    cap_pin <= l;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic ack(input t16cc_flags_t f);
    vack <= f;
    @(posedge ref_clk);
    vack <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({16'h0000, top_val}, 32'h0000_FFFF);
    rd(`T16CC_OFS_MASK, '0);
    rd(`T16CC_OFS_FLAGS, '0);
    rd(`T16CC_OFS_CTRL, '0);
    apb(1'b0, 8'h24, '0, q, e);
    chk(q, '0);
    chk({31'h0, e}, 8'h01);
    // High byte first through the shared latch
    wr(`T16CC_OFS_CMPA_H, 8'h12);
    wr(`T16CC_OFS_CMPA_L, 8'h34);
    wr(`T16CC_OFS_CMPB_H, 8'h12);
    wr(`T16CC_OFS_CMPB_L, 8'h36);
    rd(`T16CC_OFS_CMPA_L, 8'h34);
    rd(`T16CC_OFS_CMPA_H, 8'h12);
    rd(`T16CC_OFS_CMPB_L, 8'h36);
    rd(`T16CC_OFS_CMPB_H, 8'h12);
    // One tick on the match, no later tick yet
    tick(16'h1234, 1);
    rd(`T16CC_OFS_FLAGS, '0);
    tick(16'h1235, 3);
    rd(`T16CC_OFS_FLAGS, 8'h18);
    wr(`T16CC_OFS_MASK, 8'h18);
    chk({28'h0, irq}, '0);
    gie <= 1'b1;
    @(posedge ref_clk);
    chk({28'h0, irq}, 8'h06);
    wr(`T16CC_OFS_FLAGS, 8'h10);
    rd(`T16CC_OFS_FLAGS, 8'h08);
    wr(`T16CC_OFS_FLAGS, 8'h00);
    rd(`T16CC_OFS_FLAGS, 8'h08);
    chk({28'h0, irq}, 8'h02);
    ack(4'b0010);
    rd(`T16CC_OFS_FLAGS, '0);
    wr(`T16CC_OFS_CTRL, 32'h0000_0300);
    rd(`T16CC_OFS_CTRL, '0);
    rd(`T16CC_OFS_FLAGS, '0);
    chk(n_ma, 32'h0000_0002);
    chk(n_mb, 32'h0000_0002);
    wr(`T16CC_OFS_MASK, 8'h04);
    tick(16'hFFFE, 2);
    rd(`T16CC_OFS_FLAGS, 8'h04);
    chk({28'h0, irq}, 8'h01);
    wr(`T16CC_OFS_FLAGS, 8'h04);
    rd(`T16CC_OFS_FLAGS, '0);
    tick(16'hFFFF, 1);
    ack(4'b0001);
    rd(`T16CC_OFS_FLAGS, '0);
    // Falling edge captures while edge select is zero
    wr(`T16CC_OFS_MASK, 8'h20);
    tick(16'h4321, 1);
    pin(1'b0);
    rd(`T16CC_OFS_CAP_L, 8'h22);
    rd(`T16CC_OFS_CAP_H, 8'h43);
    chk({28'h0, irq}, 8'h08);
    rd(`T16CC_OFS_FLAGS, 8'h20);
    wr(`T16CC_OFS_FLAGS, 8'h20);
    rd(`T16CC_OFS_FLAGS, '0);
    tick(16'h5555, 1);
    pin(1'b1);
    rd(`T16CC_OFS_CAP_L, 8'h22);
    rd(`T16CC_OFS_FLAGS, '0);
    wr(`T16CC_OFS_CTRL, 8'h40);
    pin(1'b0);
    tick(16'h6000, 1);
    pin(1'b1);
    rd(`T16CC_OFS_CAP_L, 8'h01);
    rd(`T16CC_OFS_CAP_H, 8'h60);
    ack(4'b1000);
    rd(`T16CC_OFS_FLAGS, '0);
    // Comparator as the event source
    wr(`T16CC_OFS_CTRL, 8'hC0);
    tick(16'h7000, 1);
    analog <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`T16CC_OFS_CAP_L, 8'h01);
    rd(`T16CC_OFS_CAP_H, 8'h70);
    wr(`T16CC_OFS_FLAGS, 8'h20);
    // Capture value as top: pin ignored, flag at top
    wr(`T16CC_OFS_CTRL, 8'h0C);
    repeat (2) @(posedge ref_clk);
    chk({16'h0000, top_val}, 32'h0000_7001);
    chk({28'h0, wmode}, 32'h0000_000C);
    tick(16'h1000, 1);
    pin(1'b0);
    rd(`T16CC_OFS_CAP_L, 8'h01);
    rd(`T16CC_OFS_FLAGS, '0);
    tick(16'h7000, 2);
    rd(`T16CC_OFS_FLAGS, 8'h20);
    chk(n_ma, 32'h0000_0002);
    results();
  end
endmodule // tb_t16cc_top
